// File: hdl/eight_bit_timer_mode_control.sv
// Function
// - writing the count-run bit to 0 stops the counter until it is set again.
// - mode bit 0 clears and restarts on compare match, 1 runs free as PWM.
// - set/clear bits force the output flip-flop high/low, 00 keeps it, 11 is banned.
// - inversion bit enables toggling outside PWM and picks active-low in PWM.
// - output enable 0 holds the timer output pin low, 1 lets the timer drive it.
// - the set and clear bits at positions 3 and 2 are write-only and read 0.
// - set and clear writes are ignored while in PWM mode.
// - in PWM mode clearing the run bit drives the output inactive.
// - mode, preset, polarity and enable act on the pin whether running or not.
// - reset clears the pin-route select register to zero.
// - route field 00 none, 01 first pin, 10 second pin; 11 is not written.
// - by default the interrupt and wide timer inputs sit on the second pin.
module eight_bit_timer_mode_control
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_bit_wr,
   input wire logic [2:0] reg_bit_idx,
   input wire logic reg_bit_val,
   input wire logic reg_rd,
   input wire logic count_tick,
   input wire logic [7:0] compare_value,
   input wire logic route_pin_first,
   input wire logic route_pin_second,
   output logic [7:0] reg_rdata,
   output logic timer_output_pin,
   output logic timer_input_pin,
   output logic external_interrupt_input,
   output logic wide_timer_input,
   output logic high_res_timer_output_assigned,
   output logic [7:0] eight_bit_counter,
   output logic compare_match
);
   logic [7:0] timer_mode_control_q;
   logic [7:0] pin_route_select_q;
   logic flipflop_q;
   logic sel_tmc;
   logic sel_route;
   logic any_wr;
   logic [7:0] tmc_view;
   logic [7:0] route_view;
   logic [7:0] tmc_wr_val;
   logic [7:0] route_wr_val;
   logic count_run_bit;
   logic mode_select_bit;
   logic inversion_polarity_bit;
   logic output_enable_bit;
   logic flipflop_set_bit;
   logic flipflop_clear_bit;
   logic [7:0] count_val;
   logic match_pulse;
   logic wrap_pulse;
   logic pwm_active;
   logic pin_level;
   input_route_t input_route;

   assign sel_tmc = (reg_addr == TIMER_MODE_CONTROL_ADDR);
   assign sel_route = (reg_addr == PIN_ROUTE_SELECT_ADDR);
   assign any_wr = reg_wr || reg_bit_wr;

   // stored bits only; write-only preset bits always show as zero
   assign tmc_view = timer_mode_control_q & TIMER_MODE_STORED_MASK;
   assign route_view = pin_route_select_q & PIN_ROUTE_STORED_MASK;

   // a 1-bit write merges into what a read returns, so preset bits stay 0
   always_comb
   begin
      tmc_wr_val = tmc_view;
      route_wr_val = route_view;
      if (reg_wr)
      begin
         tmc_wr_val = reg_wdata;
         route_wr_val = reg_wdata;
      end
      else
      begin
         tmc_wr_val[reg_bit_idx] = reg_bit_val;
         route_wr_val[reg_bit_idx] = reg_bit_val;
      end
   end

   assign flipflop_set_bit = tmc_wr_val[FLIPFLOP_SET_POS];
   assign flipflop_clear_bit = tmc_wr_val[FLIPFLOP_CLEAR_POS];
   assign count_run_bit = timer_mode_control_q[COUNT_RUN_POS];
   assign mode_select_bit = timer_mode_control_q[MODE_SELECT_POS];
   assign inversion_polarity_bit =
      timer_mode_control_q[INVERSION_POLARITY_POS];
   assign output_enable_bit = timer_mode_control_q[OUTPUT_ENABLE_POS];
   assign input_route = input_route_t'(route_view[1:0]);

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         timer_mode_control_q <= TIMER_MODE_CONTROL_RESET;
      end
      else if (clk_en && any_wr && sel_tmc)
      begin
         timer_mode_control_q <= tmc_wr_val & TIMER_MODE_STORED_MASK;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         pin_route_select_q <= PIN_ROUTE_SELECT_RESET;
      end
      else if (clk_en && any_wr && sel_route)
      begin
         pin_route_select_q <= route_wr_val & PIN_ROUTE_STORED_MASK;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         reg_rdata <= 8'h00;
      end
      else if (clk_en && reg_rd)
      begin
         if (sel_tmc)
         begin
            reg_rdata <= tmc_view;
         end
         else if (sel_route)
         begin
            reg_rdata <= route_view;
         end
         else
         begin
            reg_rdata <= 8'h00;
         end
      end
   end

   timer_counter_core u_core
   (
      .clk_sys(clk_sys),
      .reset(reset),
      .clk_en(clk_en),
      .run(count_run_bit),
      .pwm_mode(mode_select_bit),
      .count_tick(count_tick),
      .compare_value(compare_value),
      .count_q(count_val),
      .match_q(match_pulse),
      .wrap_q(wrap_pulse)
   );

   // output flip-flop: preset wins over a toggle landing in the same cycle,
   // since software expects the level it just wrote
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         flipflop_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (any_wr && sel_tmc && !tmc_wr_val[MODE_SELECT_POS]
             && !mode_select_bit && (flipflop_set_bit ^ flipflop_clear_bit))
         begin
            flipflop_q <= flipflop_set_bit;
         end
         else if (!mode_select_bit && inversion_polarity_bit && match_pulse)
         begin
            flipflop_q <= ~flipflop_q;
         end
      end
   end

   // pwm: active from wrap to match; stopped counter means inactive
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         pwm_active <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!count_run_bit || !mode_select_bit)
         begin
            pwm_active <= 1'b0;
         end
         else if (match_pulse)
         begin
            pwm_active <= 1'b0;
         end
         else if (wrap_pulse)
         begin
            pwm_active <= 1'b1;
         end
      end
   end

   // pin follows the settings regardless of the run bit
   assign pin_level = mode_select_bit ? (pwm_active ^ inversion_polarity_bit)
                                      : flipflop_q;

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         timer_output_pin <= 1'b0;
      end
      else if (clk_en)
      begin
         timer_output_pin <= output_enable_bit && pin_level;
      end
   end

   // input routing; the forbidden code 11 behaves as no assignment
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         timer_input_pin <= 1'b0;
         external_interrupt_input <= 1'b0;
         wide_timer_input <= 1'b0;
         high_res_timer_output_assigned <= 1'b0;
      end
      else if (clk_en)
      begin
         case (input_route)
            ROUTE_FIRST: timer_input_pin <= route_pin_first;
            ROUTE_SECOND: timer_input_pin <= route_pin_second;
            default: timer_input_pin <= 1'b0;
         endcase
         external_interrupt_input <= route_pin_second;
         wide_timer_input <= route_pin_second;
         high_res_timer_output_assigned <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         eight_bit_counter <= COUNT_ZERO;
         compare_match <= 1'b0;
      end
      else if (clk_en)
      begin
         eight_bit_counter <= count_val;
         compare_match <= match_pulse;
      end
   end
endmodule // eight_bit_timer_mode_control

// File: hdl/timer_counter_core.sv
module timer_counter_core
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic run,
   input wire logic pwm_mode,
   input wire logic count_tick,
   input wire logic [7:0] compare_value,
   output logic [7:0] count_q,
   output logic match_q,
   output logic wrap_q
);
   logic at_match;
   logic at_max;

   assign at_match = (count_q == compare_value);
   assign at_max = (count_q == COUNT_MAX);

   // counter held at zero while stopped, so a restart begins from zero
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         count_q <= COUNT_ZERO;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            count_q <= COUNT_ZERO;
         end
         else if (count_tick)
         begin
            if (!pwm_mode && at_match)
            begin
               count_q <= COUNT_ZERO;
            end
            else
            begin
               count_q <= count_q + COUNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         match_q <= 1'b0;
         wrap_q <= 1'b0;
      end
      else if (clk_en)
      begin
         match_q <= run && count_tick && at_match;
         wrap_q <= run && count_tick && pwm_mode && at_max;
      end
   end
endmodule // timer_counter_core

// File: hdl/timer_pkg.sv
package timer_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam logic [15:0] TIMER_MODE_CONTROL_ADDR = 16'hFF43;
   localparam logic [15:0] PIN_ROUTE_SELECT_ADDR = 16'hFF44;
   localparam logic [7:0] TIMER_MODE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] PIN_ROUTE_SELECT_RESET = 8'h00;
   localparam int unsigned COUNT_RUN_POS = 7;
   localparam int unsigned MODE_SELECT_POS = 6;
   localparam int unsigned FLIPFLOP_SET_POS = 3;
   localparam int unsigned FLIPFLOP_CLEAR_POS = 2;
   localparam int unsigned INVERSION_POLARITY_POS = 1;
   localparam int unsigned OUTPUT_ENABLE_POS = 0;
   localparam int unsigned INPUT_ROUTE_LOW_POS = 0;
   localparam int unsigned INPUT_ROUTE_HIGH_POS = 1;
   // bits that hold state; 5 and 4 are reserved, 3 and 2 are write-only
   localparam logic [7:0] TIMER_MODE_STORED_MASK = 8'hC3;
   localparam logic [7:0] PIN_ROUTE_STORED_MASK = 8'h03;
   localparam logic [7:0] COUNT_ZERO = 8'h00;
   localparam logic [7:0] COUNT_ONE = 8'h01;
   localparam logic [7:0] COUNT_MAX = 8'hFF;

   typedef enum logic [1:0]
   {
      ROUTE_NONE = 2'b00,
      ROUTE_FIRST = 2'b01,
      ROUTE_SECOND = 2'b10,
      ROUTE_BAD = 2'b11
   } input_route_t;
endpackage

// File: verif/eight_bit_timer_mode_control_tb.sv
module eight_bit_timer_mode_control_tb
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_bit_wr = 0;
   logic reg_bit_val = 0, reg_rd = 0, count_tick = 0, ff = 0, act = 0;
   logic [15:0] reg_addr = 16'hFF43, a;
   logic [7:0] reg_wdata = 8'h00, compare_value = 8'h00, d, ctl = 8'h00;
   logic [7:0] rt = 8'h00, cnt = 8'h00, reg_rdata, eight_bit_counter;
   logic [2:0] reg_bit_idx = 3'h0;
   logic [1:0] lvl = 2'h0;
   logic [31:0] s = 32'h49355610;
   logic timer_output_pin, timer_input_pin, external_interrupt_input;
   logic wide_timer_input, high_res_timer_output_assigned, compare_match;
   logic route_pin_first, route_pin_second;
   logic [7:0] q[$];
   int checks = 0, n_fail = 0;
   eight_bit_timer_mode_control i_eight_bit_timer_mode_control (.*);
   ext_pins i_ext_pins (.clk_sys(clk_sys), .lvl(lvl),
      .route_pin_first(route_pin_first), .route_pin_second(route_pin_second));
   initial
      forever #4 clk_sys = ~clk_sys;
   function automatic logic [31:0] nx(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic epin();
      return ctl[0] & (ctl[6] ? act ^ ctl[1] : ff);
   endfunction
   task automatic tk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic put(input logic [15:0] ad, input logic [7:0] v,
      input logic b, input logic [2:0] i);
      logic [7:0] m;
      m = b ? ((ad == PIN_ROUTE_SELECT_ADDR) ? rt : ctl) : v;
      m[i] = b ? v[0] : m[i];
      {reg_addr, reg_wdata, reg_bit_idx, reg_bit_val} = {ad, v, i, v[0]};
      {reg_wr, reg_bit_wr} = {!b, b};
      tk(1);
      {reg_wr, reg_bit_wr} = 2'b00;
      if (ad == PIN_ROUTE_SELECT_ADDR)
         rt = m & PIN_ROUTE_STORED_MASK;
      if (ad == TIMER_MODE_CONTROL_ADDR)
      begin
         if (!ctl[6] && !m[6] && (m[3] ^ m[2]))
            ff = m[3];
         if (!(m[7] && ctl[7]))
            {cnt, act} = 9'h000;
         ctl = m & TIMER_MODE_STORED_MASK;
      end
      tk(3);
      chk(timer_output_pin, epin());
   endtask
   task automatic rd(input logic [15:0] ad, input logic [7:0] e);
      reg_addr = ad;
      reg_rd = 1;
      tk(1);
      reg_rd = 0;
      tk(1);
      chk(reg_rdata, e);
   endtask
   task automatic tick();
      logic f;
      logic hit;
      f = 0;
      hit = ctl[7] && cnt == compare_value;
      count_tick = 1;
      tk(1);
      count_tick = 0;
      act = (ctl[7] && ctl[6] && cnt == 8'hFF) | (act & !hit);
      ff = ff ^ (hit & !ctl[6] & ctl[1]);
      cnt = ctl[7] ? ((hit && !ctl[6]) ? 8'h00 : cnt + 8'h01) : 8'h00;
      repeat (4)
      begin
         tk(1);
         f |= compare_match;
      end
      chk(eight_bit_counter, cnt);
      chk(timer_output_pin, epin());
      if (!ctl[6])
         chk(f, hit);
   endtask
   task automatic summarize();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #(8 * 40000);
      n_fail++;
      summarize();
   end
   initial
   begin
      tk(16);
      reset = 0;
      tk(1);
      rd(TIMER_MODE_CONTROL_ADDR, 8'h00);
      rd(PIN_ROUTE_SELECT_ADDR, 8'h00);
      $display("reset test done");
      repeat (80)
      begin
         repeat (16) s = nx(s);
         lvl = s[14:13];
         a = TIMER_MODE_CONTROL_ADDR + 16'((s[9:8] == 2'h3) ? 2'h0 : s[9:8]);
         d = {1'b0, s[6:0]};
         d[2] = d[2] & !d[3];
         d[0] = d[0] & !d[1] & (s[12:10] != 3'h7);
         put(a, d, s[9:8] == 2'h3, s[12:10]);
         rd(a, a == TIMER_MODE_CONTROL_ADDR ? ctl : a[0] ? 8'h00 : rt);
         chk(timer_input_pin, rt == 1 ? lvl[0] : rt == 2 && lvl[1]);
         chk(wide_timer_input, lvl[1]);
         chk(external_interrupt_input, lvl[1]);
         chk(high_res_timer_output_assigned, 8'h00);
      end
      $display("register test done");
      compare_value = 8'h05;
      q = '{8'h02, 8'h03, 8'h07, 8'h83};
      foreach (q[k])
         put(TIMER_MODE_CONTROL_ADDR, q[k], 1'b0, 3'h0);
      repeat (14) tick();
      put(TIMER_MODE_CONTROL_ADDR, 8'h03, 1'b0, 3'h0);
      tick();
      put(TIMER_MODE_CONTROL_ADDR, 8'h83, 1'b0, 3'h0);
      tick();
      put(TIMER_MODE_CONTROL_ADDR, 8'h03, 1'b0, 3'h0);
      $display("count test done");
      compare_value = 8'h80;
      q = '{8'h40, 8'h41, 8'hC1};
      foreach (q[k])
         put(TIMER_MODE_CONTROL_ADDR, q[k], 1'b0, 3'h0);
      repeat (258) tick();
      put(TIMER_MODE_CONTROL_ADDR, 8'h41, 1'b0, 3'h0);
      $display("pwm test done");
      summarize();
   end
endmodule // eight_bit_timer_mode_control_tb

// File: verif/ext_pins.sv
module ext_pins
(
   input wire logic clk_sys,
   input wire logic [1:0] lvl,
   output logic route_pin_first,
   output logic route_pin_second
);
   timeunit 1ns;
   timeprecision 100ps;
   // both pins set as inputs; a late edge shows the slow case
   // the output pin is watched directly, as if direction and latch are 0
   always @(posedge clk_sys)
      {route_pin_second, route_pin_first} <= #2 lvl;
endmodule // ext_pins

// File: verif/timer_ctl_props.sv
module timer_ctl_props
   import timer_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_bit_wr,
   input wire logic [2:0] reg_bit_idx,
   input wire logic reg_bit_val,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic timer_output_pin,
   input wire logic external_interrupt_input,
   input wire logic wide_timer_input,
   input wire logic high_res_timer_output_assigned,
   input wire logic [7:0] eight_bit_counter
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   logic [7:0] c_q;
   logic [7:0] w_d;
   logic [3:0] age_q;
   logic wc;
   assign wc = clk_en && (reg_wr || reg_bit_wr)
      && reg_addr == TIMER_MODE_CONTROL_ADDR;
   always_comb
   begin
      w_d = c_q;
      w_d[reg_bit_idx] = reg_bit_val;
      if (reg_wr)
         w_d = reg_wdata;
   end
   // pins lag a control write, so checks wait until it has settled
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         age_q <= 4'hF;
      else if (wc)
         age_q <= 4'h0;
      else if (age_q != 4'hF)
         age_q <= age_q + 4'h1;
   always_ff @(posedge clk_sys or posedge reset)
      if (reset)
         c_q <= 8'h00;
      else if (wc)
         c_q <= w_d & TIMER_MODE_STORED_MASK;
   oe_low_a: assert property (age_q > 4'h3 && !c_q[0]
      |-> timer_output_pin == 1'b0) else $error("pin not held low");
   stop_a: assert property (age_q > 4'h3 && !c_q[7]
      |-> eight_bit_counter == 8'h00) else $error("counter not stopped");
   pwm_idle_a: assert property (age_q > 4'h3 && c_q[6] && !c_q[7]
      |-> timer_output_pin == (c_q[0] & c_q[1])) else $error("pwm active");
   start_a: assert property ($rose(c_q[7])
      |-> eight_bit_counter == 8'h00) else $error("start not at zero");
   ctl_rd_a: assert property (clk_en && reg_rd
      && reg_addr == TIMER_MODE_CONTROL_ADDR
      |=> (reg_rdata & 8'h3C) == 8'h00) else $error("control read bits");
   route_rd_a: assert property (clk_en && reg_rd
      && reg_addr == PIN_ROUTE_SELECT_ADDR
      |=> reg_rdata[7:2] == 6'h00) else $error("route read bits");
   no_hres_a: assert property (high_res_timer_output_assigned
      == 1'b0) else $error("high res output assigned");
   copy_a: assert property (wide_timer_input
      == external_interrupt_input) else $error("shared inputs differ");
endmodule // timer_ctl_props
bind eight_bit_timer_mode_control timer_ctl_props i_timer_ctl_props (.*);
